// *** shared/adc_cfg_pkg.sv ***
// Package for the serial configuration and result interface of the converter.
// Assumes one design clock; the shift clock, chip select and data pins are asynchronous.
package adc_cfg_pkg;

  // ==========================================================================
  // Family variants
  // ==========================================================================
  typedef enum logic [1:0] {
    VARIANT_TWO_CH,
    VARIANT_ONE_CH,
    VARIANT_SIX_CH,
    VARIANT_EIGHT_CH
  } variant_t;

  // ==========================================================================
  // Widths, lengths and counts
  // ==========================================================================
  localparam int RESULT_WIDTH = 10;
  localparam int CFG_LEN_TWO = 3;
  localparam int CFG_LEN_WIDE = 6;
  localparam int CFG_MAX = 6;
  localparam logic [2:0] CFG_CNT_RESET = 3'h0;
  localparam logic [4:0] OUT_CNT_RESET = 5'h00;
  // MSB-first word alone, and MSB-first followed by LSB-first sharing the LSB
  localparam logic [4:0] OUT_LEN_MSB_ONLY = 5'h0A;
  localparam logic [4:0] OUT_LEN_BOTH = 5'h13;

  // ==========================================================================
  // Field positions in the received word (first bit received is highest)
  // ==========================================================================
  localparam int TWO_SGL_POS = 2;
  localparam int TWO_ODD_POS = 1;
  localparam int TWO_BIT_ORDER_FLAG_POS = 0;
  localparam int WIDE_SGL_POS = 5;
  localparam int WIDE_ODD_POS = 4;
  localparam int WIDE_SEL1_POS = 3;
  localparam int WIDE_SEL0_POS = 2;
  localparam int WIDE_UNI_POS = 1;
  localparam int WIDE_BIT_ORDER_FLAG_POS = 0;
  localparam logic [1:0] SIX_UNUSED_SEL = 2'h3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [5:0] CFG_WORD_RESET = 6'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // ==========================================================================
  // Interface states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HUNT,
    ST_CONFIG,
    ST_NULL,
    ST_SHIFT,
    ST_FILL
  } link_state_t;

  // Multiplexer and conversion settings handed to the analog core
  typedef struct packed {
    logic [2:0] pos_channel;
    logic [2:0] neg_channel;
    logic neg_is_reference;
    logic polarity_mode_flag;
    logic bit_order_flag;
    logic select_unused;
  } mux_setting_t;

  localparam mux_setting_t MUX_RESET = '{
    pos_channel: 3'h0,
    neg_channel: 3'h1,
    neg_is_reference: 1'b0,
    polarity_mode_flag: 1'b1,
    bit_order_flag: 1'b0,
    select_unused: 1'b0
  };

endpackage

// *** rtl/adc_serial_config_interface.sv ***
// Control and serial interface logic of a 10-bit converter family.
// Assumes pins arrive asynchronous to clk; the analog core reads mux_setting and
// presents its result on result_code before the falling edge that starts driving the null bit.
//
// What this block does
// (RULE_01) Data out changes on shift-clock falling edges; data in sampled on rising edges.
// (RULE_02) Half-duplex: configuration received first, result sent afterwards.
// (RULE_03) Chip select falling starts an exchange and the start-bit search.
// (RULE_04) First one sampled after chip select falls is the start bit.
// (RULE_05) After start bit shift in 3 or 6 configuration bits, then convert.
// (RULE_06) Data input ignored after the configuration word until next exchange.
// (RULE_07) One null bit, then the conversion result on data out.
// (RULE_08) Chip select high returns the interface to idle.
// (RULE_09) Result is a 10-bit successive-approximation code.
// (RULE_10) Fixed variant: first clock pulse enables output, null bit, then result.
// (RULE_11) Fixed variant: unipolar differential, MSB-first then LSB-first.
// (RULE_12) Configuration bits set mux; positive channel measured against negative one.
// (RULE_13) Single-ended reference is ground or the common input.
// (RULE_14) Two-channel encoding by single/diff and polarity bits.
// (RULE_15) Six-channel encoding; select code 11 unused.
// (RULE_16) Eight-channel encoding; all select codes valid.
// (RULE_17) Bit-order one: MSB-first only; zero: LSB-first copy follows.
// (RULE_18) Polarity-mode one: unipolar binary; zero: bipolar two's complement.
// (RULE_19) Zeros after last bit; output disabled when chip select rises.
// (RULE_20) Tied lines: two-channel drives low on 4th falling edge after start.
// (RULE_21) Field order: sgl, odd, bit_order_flag; or sgl, odd, sel1, sel0, uni, bit_order_flag.
// (RULE_22) Unused six-channel code still completes the exchange, result zero.
// (RULE_23) Data out released while receiving start bit and configuration.
`timescale 1ns/10ps

module adc_serial_config_interface #(
  parameter adc_cfg_pkg::variant_t VARIANT = adc_cfg_pkg::VARIANT_EIGHT_CH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n_pin,
  input wire logic shift_clock_pin,
  input wire logic data_in_pin,
  output logic data_out,
  output logic data_out_oe,
  input wire logic [adc_cfg_pkg::RESULT_WIDTH-1:0] result_code,
  output logic conversion_start,
  output adc_cfg_pkg::mux_setting_t mux_setting
);
  import adc_cfg_pkg::*;

  // ==========================================================================
  // Functions
  // ==========================================================================

  // Length of the configuration word for this variant
  function automatic logic [2:0] cfg_length(input variant_t v);
    unique case (v)
      VARIANT_TWO_CH: cfg_length = 3'(CFG_LEN_TWO);
      VARIANT_ONE_CH: cfg_length = 3'h0;
      VARIANT_SIX_CH: cfg_length = 3'(CFG_LEN_WIDE);
      VARIANT_EIGHT_CH: cfg_length = 3'(CFG_LEN_WIDE);
    endcase
  endfunction

  // Turn a received configuration word into the multiplexer setting
  function automatic mux_setting_t decode_cfg(input variant_t v, input logic [5:0] w);
    mux_setting_t s;
    logic [1:0] sel;
    logic sgl;
    logic odd;
    s = MUX_RESET;
    sel = 2'h0;
    sgl = 1'b0;
    odd = 1'b0;
    unique case (v)
      VARIANT_TWO_CH: begin
        sgl = w[TWO_SGL_POS];
        odd = w[TWO_ODD_POS];
        s.polarity_mode_flag = 1'b1;
        s.bit_order_flag = w[TWO_BIT_ORDER_FLAG_POS];
      end
      VARIANT_ONE_CH: begin
        // Fixed: channel 0 positive, channel 1 negative, both orders sent
        sgl = 1'b0; // RULE_11
        odd = 1'b0;
        s.polarity_mode_flag = 1'b1; // RULE_11
        s.bit_order_flag = 1'b0; // RULE_11
      end
      default: begin
        sgl = w[WIDE_SGL_POS]; // RULE_21
        odd = w[WIDE_ODD_POS];
        sel = {w[WIDE_SEL1_POS], w[WIDE_SEL0_POS]};
        s.polarity_mode_flag = w[WIDE_UNI_POS]; // RULE_18
        s.bit_order_flag = w[WIDE_BIT_ORDER_FLAG_POS];
      end
    endcase
    // Pair base from select bits; polarity bit picks sign or odd channel
    s.pos_channel = {sel, odd}; // RULE_12 RULE_14 RULE_15 RULE_16
    s.neg_channel = {sel, ~odd}; // RULE_12
    // Single-ended: negative side is ground (two-channel) or the common input
    s.neg_is_reference = sgl; // RULE_13
    s.select_unused = (v == VARIANT_SIX_CH) && (sel == SIX_UNUSED_SEL); // RULE_15 RULE_22
    return s;
  endfunction

  // Bit to send at position k of the output sequence
  function automatic logic result_bit(input logic [9:0] r, input logic [4:0] k);
    logic [4:0] idx;
    idx = 5'h00;
    if (k < OUT_LEN_MSB_ONLY) begin
      idx = 5'(RESULT_WIDTH - 1) - k; // MSB-first part
    end else begin
      idx = k - 5'(RESULT_WIDTH - 1); // LSB-first copy, LSB shared
    end
    return r[idx[3:0]];
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic cs_n_meta_reg;
  logic cs_n_sync_reg;
  logic sclk_meta_reg;
  logic sclk_sync_reg;
  logic sclk_prev_reg;
  logic din_meta_reg;
  logic din_sync_reg;
  logic sclk_rise;
  logic sclk_fall;

  // Two flops per pin; logic uses the second stage, plus a third shift-clock flop for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_n_meta_reg <= 1'b1;
      cs_n_sync_reg <= 1'b1;
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
    end else begin
      cs_n_meta_reg <= chip_select_n_pin;
      cs_n_sync_reg <= cs_n_meta_reg;
      sclk_meta_reg <= shift_clock_pin;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      din_meta_reg <= data_in_pin;
      din_sync_reg <= din_meta_reg;
    end
  end

  // Edge detection on the synchronised shift clock
  assign sclk_rise = sclk_sync_reg & ~sclk_prev_reg; // RULE_01
  assign sclk_fall = ~sclk_sync_reg & sclk_prev_reg; // RULE_01

  // ==========================================================================
  // Exchange sequencer
  // ==========================================================================
  link_state_t state_reg;
  link_state_t state_next;
  logic [5:0] cfg_word_reg;
  logic [5:0] cfg_word_next;
  logic [2:0] cfg_cnt_reg;
  logic [2:0] cfg_cnt_next;
  logic [4:0] out_cnt_reg;
  logic [4:0] out_cnt_next;
  logic [4:0] out_len_reg;
  logic [4:0] out_len_next;
  logic [9:0] result_reg;
  logic [9:0] result_next;
  mux_setting_t mux_reg;
  mux_setting_t mux_next;
  logic start_reg;
  logic start_next;
  logic dout_reg;
  logic dout_next;
  logic oe_reg;
  logic oe_next;
  mux_setting_t decoded;

  // Decode of the word including the bit arriving now, for the final rising edge
  assign decoded = decode_cfg(VARIANT, {cfg_word_reg[4:0], din_sync_reg});

  // Next-state logic of the whole exchange
  always_comb begin
    state_next = state_reg;
    cfg_word_next = cfg_word_reg;
    cfg_cnt_next = cfg_cnt_reg;
    out_cnt_next = out_cnt_reg;
    out_len_next = out_len_reg;
    result_next = result_reg;
    mux_next = mux_reg;
    start_next = 1'b0;
    dout_next = dout_reg;
    oe_next = oe_reg;
    if (cs_n_sync_reg) begin
      // Chip select high: back to idle, output released
      state_next = ST_IDLE; // RULE_08
      oe_next = 1'b0; // RULE_19
      dout_next = 1'b0;
      cfg_cnt_next = CFG_CNT_RESET;
      out_cnt_next = OUT_CNT_RESET;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // Chip select has fallen: look for the start bit
          state_next = ST_HUNT; // RULE_03
          cfg_word_next = CFG_WORD_RESET;
        end
        ST_HUNT: begin
          if (sclk_rise) begin
            if (VARIANT == VARIANT_ONE_CH) begin
              // First clock pulse arms the output without any input word
              mux_next = decode_cfg(VARIANT, CFG_WORD_RESET); // RULE_10 RULE_11
              start_next = 1'b1;
              state_next = ST_NULL; // RULE_10
            end else if (din_sync_reg) begin
              state_next = ST_CONFIG; // RULE_04
            end
          end
        end
        ST_CONFIG: begin
          // Output stays released while the word comes in
          oe_next = 1'b0; // RULE_23 RULE_02
          if (sclk_rise) begin
            cfg_word_next = {cfg_word_reg[4:0], din_sync_reg}; // RULE_05
            cfg_cnt_next = cfg_cnt_reg + 3'h1;
            if (cfg_cnt_reg + 3'h1 == cfg_length(VARIANT)) begin
              mux_next = decoded; // RULE_12
              start_next = 1'b1; // RULE_05
              state_next = ST_NULL;
            end
          end
        end
        ST_NULL: begin
          // First falling edge after the word: drive the null bit low
          if (sclk_fall) begin
            oe_next = 1'b1; // RULE_20 RULE_07
            dout_next = 1'b0; // RULE_07
            // Unused code completes timing with a zero result
            result_next = mux_reg.select_unused ? RESULT_RESET : result_code; // RULE_22 RULE_09
            out_len_next = mux_reg.bit_order_flag ? OUT_LEN_MSB_ONLY : OUT_LEN_BOTH; // RULE_17
            out_cnt_next = OUT_CNT_RESET;
            state_next = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // Result bits change on falling edges; data input ignored
          if (sclk_fall) begin
            dout_next = result_bit(result_reg, out_cnt_reg); // RULE_01 RULE_06
            out_cnt_next = out_cnt_reg + 5'h01;
            if (out_cnt_reg + 5'h01 == out_len_reg) begin
              state_next = ST_FILL;
            end
          end
        end
        ST_FILL: begin
          // Zeros for as long as chip select stays low
          if (sclk_fall) begin
            dout_next = 1'b0; // RULE_19
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // Registers of the sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cfg_word_reg <= CFG_WORD_RESET;
      cfg_cnt_reg <= CFG_CNT_RESET;
      out_cnt_reg <= OUT_CNT_RESET;
      out_len_reg <= OUT_LEN_BOTH;
      result_reg <= RESULT_RESET;
      mux_reg <= MUX_RESET;
      start_reg <= 1'b0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_word_reg <= cfg_word_next;
      cfg_cnt_reg <= cfg_cnt_next;
      out_cnt_reg <= out_cnt_next;
      out_len_reg <= out_len_next;
      result_reg <= result_next;
      mux_reg <= mux_next;
      start_reg <= start_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign data_out = dout_reg;
  assign data_out_oe = oe_reg;
  assign conversion_start = start_reg;
  assign mux_setting = mux_reg;

endmodule // adc_serial_config_interface

// *** sim/adc_cfg_checker.sv ***
// Checker for the converter serial interface, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module adc_cfg_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n_pin,
  input wire logic shift_clock_pin,
  input wire logic data_in_pin,
  input wire logic data_out,
  input wire logic data_out_oe,
  input wire logic [adc_cfg_pkg::RESULT_WIDTH-1:0] result_code,
  input wire logic conversion_start,
  input wire adc_cfg_pkg::mux_setting_t mux_setting
);
  import adc_cfg_pkg::*;
  // ==========================================================================
  // Sequences
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Chip select held high long enough to pass the synchroniser
  sequence s_cs_idle;
    chip_select_n_pin [*8];
  endsequence
  // Line stays released right after the word completes
  sequence s_quiet;
    !data_out_oe [*4];
  endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_IDLE_LOW: assert property (!data_out_oe |-> !data_out)
    else $error("data out not low while released");
  AST_CS_RELEASE: assert property (s_cs_idle |-> !data_out_oe)
    else $error("output still driven with chip select high");
  AST_START_PULSE: assert property (conversion_start |=> !conversion_start)
    else $error("conversion start longer than one cycle");
  AST_QUIET_AFTER_CFG: assert property (conversion_start |-> s_quiet)
    else $error("output driven too soon after configuration");
  AST_MUX_WITH_START: assert property ($changed(mux_setting) |->
    conversion_start || $past(conversion_start))
    else $error("mux setting changed without a conversion start");
  AST_OE_NEEDS_CS: assert property ($rose(data_out_oe) |-> !chip_select_n_pin)
    else $error("output enabled with chip select high");
  AST_DOUT_ON_FALL: assert property (data_out_oe && $past(data_out_oe) && $changed(data_out)
    |-> !shift_clock_pin)
    else $error("data out changed while shift clock high");
  AST_START_NEEDS_CS: assert property (conversion_start |-> !chip_select_n_pin)
    else $error("conversion started outside an exchange");
endmodule // adc_cfg_checker

bind adc_serial_config_interface adc_cfg_checker chk (.clk(clk), .reset(reset),
  .chip_select_n_pin(chip_select_n_pin), .shift_clock_pin(shift_clock_pin),
  .data_in_pin(data_in_pin), .data_out(data_out), .data_out_oe(data_out_oe),
  .result_code(result_code), .conversion_start(conversion_start), .mux_setting(mux_setting));

// *** sim/host_serial_model.sv ***
// Host model: drives chip select, shift clock and data in, reads data out.
// Assumes a 4 ns design clock; one shift period is 16 design clocks.
`timescale 1ns/10ps
module host_serial_model (
  input wire logic clk,
  input wire logic data_out,
  input wire logic data_out_oe,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  // Idle pins at time zero; shift clock stands still low outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Half a shift period, launched just after a design clock edge
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // One exchange: leading zeros, start bit, word, then nout bits read back
  task automatic xfer(input int lead, input int ncfg, input logic [5:0] cfg, input int nout,
                      output logic [23:0] got, output logic early, output logic gap);
    got = '0;
    early = 1'b0;
    gap = 1'b0;
    cs_n = 1'b0;
    half();
    for (int i = 0; i < lead + 1 + ncfg; i++) begin
      din = (i < lead) ? 1'b0 : (i == lead) ? 1'b1 : cfg[lead + ncfg - i];
      half();
      sclk = 1'b1;
      early |= data_out_oe;
      half();
      sclk = 1'b0;
    end
    for (int i = 0; i < nout; i++) begin
      din = ~din; // Leftover input keeps changing
      half();
      sclk = 1'b1;
      got = {got[22:0], data_out};
      gap |= !data_out_oe;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    half();
  endtask
  // Exchange cut short after nbits ones
  task automatic abort_after(input int nbits);
    cs_n = 1'b0;
    half();
    for (int i = 0; i < nbits; i++) begin
      din = 1'b1;
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    half();
  endtask
endmodule // host_serial_model

// *** sim/tb.sv ***
// Testbench for the converter family serial interface, one instance per variant.
// Assumes the host model in its own file and the bound checker.
`timescale 1ns/10ps
module tb;
  import adc_cfg_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, sclk, din, data_out, data_out_oe, conversion_start;
  logic [RESULT_WIDTH-1:0] result_code = 10'h000;
  mux_setting_t mux_setting;
  int failures = 0;
  int checks = 0;
  int starts = 0;
  // Variant instances: index 0 two-channel, 1 six-channel, 2 fixed
  wire [2:0] v_cs_n, v_sclk, v_din, v_dout, v_oe, v_start;
  mux_setting_t mux_two, mux_six, mux_one;
  int v_starts [3] = '{0, 0, 0};
  // ==========================================================================
  // Clock, design and host
  // ==========================================================================
  always #2 clk = ~clk;
  adc_serial_config_interface #(.VARIANT(VARIANT_EIGHT_CH)) uut (.clk(clk), .reset(reset),
    .chip_select_n_pin(cs_n), .shift_clock_pin(sclk), .data_in_pin(din),
    .data_out(data_out), .data_out_oe(data_out_oe), .result_code(result_code),
    .conversion_start(conversion_start), .mux_setting(mux_setting));
  host_serial_model host (.clk(clk), .data_out(data_out), .data_out_oe(data_out_oe),
    .cs_n(cs_n), .sclk(sclk), .din(din));
  adc_serial_config_interface #(.VARIANT(VARIANT_TWO_CH)) uut_two (.clk(clk), .reset(reset),
    .chip_select_n_pin(v_cs_n[0]), .shift_clock_pin(v_sclk[0]), .data_in_pin(v_din[0]),
    .data_out(v_dout[0]), .data_out_oe(v_oe[0]), .result_code(result_code),
    .conversion_start(v_start[0]), .mux_setting(mux_two));
  host_serial_model host_two (.clk(clk), .data_out(v_dout[0]), .data_out_oe(v_oe[0]),
    .cs_n(v_cs_n[0]), .sclk(v_sclk[0]), .din(v_din[0]));
  adc_serial_config_interface #(.VARIANT(VARIANT_SIX_CH)) uut_six (.clk(clk), .reset(reset),
    .chip_select_n_pin(v_cs_n[1]), .shift_clock_pin(v_sclk[1]), .data_in_pin(v_din[1]),
    .data_out(v_dout[1]), .data_out_oe(v_oe[1]), .result_code(result_code),
    .conversion_start(v_start[1]), .mux_setting(mux_six));
  host_serial_model host_six (.clk(clk), .data_out(v_dout[1]), .data_out_oe(v_oe[1]),
    .cs_n(v_cs_n[1]), .sclk(v_sclk[1]), .din(v_din[1]));
  adc_serial_config_interface #(.VARIANT(VARIANT_ONE_CH)) uut_one (.clk(clk), .reset(reset),
    .chip_select_n_pin(v_cs_n[2]), .shift_clock_pin(v_sclk[2]), .data_in_pin(v_din[2]),
    .data_out(v_dout[2]), .data_out_oe(v_oe[2]), .result_code(result_code),
    .conversion_start(v_start[2]), .mux_setting(mux_one));
  host_serial_model host_one (.clk(clk), .data_out(v_dout[2]), .data_out_oe(v_oe[2]),
    .cs_n(v_cs_n[2]), .sclk(v_sclk[2]), .din(v_din[2]));
  // Count conversion start pulses
  always @(posedge clk) if (conversion_start === 1'b1) starts <= starts + 1;
  // Count start pulses of the variant instances
  always @(posedge clk) begin
    for (int k = 0; k < 3; k++) begin
      if (v_start[k] === 1'b1) v_starts[k] <= v_starts[k] + 1;
    end
  end
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected line: null, MSB-first word, then the LSB-first copy sharing B0 when asked
  function automatic logic [23:0] stream(input logic [9:0] res, input logic both);
    stream = '0;
    for (int i = 0; i < 10; i++) stream[22 - i] = res[9 - i];
    if (both) for (int i = 1; i < 10; i++) stream[13 - i] = res[i];
  endfunction
  // One exchange on a variant instance with stream, mux, start and enable checks
  task automatic run_var(input int k, input int lead, input int ncfg, input logic [5:0] cfg,
                         input logic [9:0] res, input logic [23:0] exp, input mux_setting_t m);
    logic [23:0] got;
    logic early, gap;
    mux_setting_t ms;
    int s0;
    s0 = v_starts[k];
    result_code = res;
    case (k)
      0: host_two.xfer(lead, ncfg, cfg, 24, got, early, gap);
      1: host_six.xfer(lead, ncfg, cfg, 24, got, early, gap);
      default: host_one.xfer(lead, ncfg, cfg, 24, got, early, gap);
    endcase
    ms = (k == 0) ? mux_two : (k == 1) ? mux_six : mux_one;
    cmp(got, exp);
    cmp(24'(ms), 24'(m));
    cmp({early, gap, v_starts[k] - s0 == 1, v_oe[k]}, 24'h000002);
  endtask
  // One full exchange with stream, mux and enable checks
  task automatic run(input int lead, input logic [5:0] cfg, input logic [9:0] res);
    logic [23:0] got, exp;
    logic early, gap;
    mux_setting_t m;
    int s0;
    exp = stream(res, !cfg[0]);
    m = '{pos_channel: {cfg[3:2], cfg[4]}, neg_channel: {cfg[3:2], ~cfg[4]},
      neg_is_reference: cfg[5], polarity_mode_flag: cfg[1], bit_order_flag: cfg[0],
      select_unused: 1'b0};
    s0 = starts;
    result_code = res;
    host.xfer(lead, 6, cfg, 24, got, early, gap);
    cmp(got, exp);
    cmp(24'(mux_setting), 24'(m));
    cmp({early, gap, starts - s0 == 1, data_out_oe}, 24'h000002);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic sc_lead_zeros();
    run(5, 6'h08, 10'h2B5);
  endtask
  task automatic sc_single_bit_order_flag();
    run(0, 6'h3F, 10'h3C1);
  endtask
  task automatic sc_all_selects();
    for (int s = 0; s < 4; s++) run(1, {2'b01, 2'(s), 2'b10}, 10'h155 ^ 10'(s));
  endtask
  task automatic sc_two_channel();
    run_var(0, 1, 3, 6'h03, 10'h1A7, stream(10'h1A7, 1'b0),
      '{3'h1, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0});
    run_var(0, 3, 3, 6'h04, 10'h25C, stream(10'h25C, 1'b1),
      '{3'h0, 3'h1, 1'b1, 1'b1, 1'b0, 1'b0});
  endtask
  task automatic sc_six_channel();
    run_var(1, 0, 6, 6'h0F, 10'h3FF, 24'h000000,
      '{3'h6, 3'h7, 1'b0, 1'b1, 1'b1, 1'b1});
    run_var(1, 2, 6, 6'h38, 10'h0C3, stream(10'h0C3, 1'b1),
      '{3'h5, 3'h4, 1'b1, 1'b0, 1'b0, 1'b0});
  endtask
  task automatic sc_fixed();
    run_var(2, 0, 0, 6'h00, 10'h2D3, stream(10'h2D3, 1'b1),
      '{3'h0, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0});
  endtask
  task automatic sc_abort();
    int s0;
    s0 = starts;
    host.abort_after(3);
    cmp({starts == s0, data_out_oe}, 24'h000002);
    run(2, 6'h26, 10'h0F0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    sc_lead_zeros();
    sc_single_bit_order_flag();
    sc_all_selects();
    sc_abort();
    sc_two_channel();
    sc_six_channel();
    sc_fixed();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule // tb
